// ---- instr_cycle_timing.v ----
// Instruction cycle sequencer with stretched external data access
// Summary of operation
// - Each machine cycle is four states, first to fourth, in order.
// - Sequencing acts only on the rising clock edge.
// - One instruction byte fetched per machine cycle at most.
// - Whole opcode space decoded; 170 of the 256 opcodes are single-cycle.
// - External data move needs a second cycle for its bus access.
// - Lengths are one to four cycles; data move is variable.
// - Data move fetches opcode, then drives address and accesses.
// - Data move lasts two to nine cycles; strobe widens accordingly.
// - Stretch field is bits two to zero of clock control register.
// - Stretch field resets to one: three cycles, four-clock strobe.
// - Stretch n gives n+2 cycles; strobe 2 clocks or 4n clocks.
// - Stretch affects only data moves; others keep their timing.
// - Compare, bit and direct decrement branches take four cycles.
`timescale 1ns/10ps
`default_nettype none
`include "cycle_timing_defines.vh"
module instr_cycle_timing
(
  input wire clk_in,
  input wire rst_b_in,
  input wire ce_in,
  input wire clock_control_register_wr_in,
  input wire [7:0] clock_control_register_data_in,
  input wire [7:0] code_byte_in,
  input wire [15:0] xdata_addr_in,
  output reg [7:0] clock_control_register_out,
  output wire [3:0] state_out,
  output reg fetch_out,
  output reg instr_done_out,
  output reg [15:0] ext_addr_out,
  output reg ext_addr_valid_out,
  output reg rd_b_out,
  output reg wr_b_out
);
  reg [7:0] clock_control_register;
  reg [7:0] opcode;
  reg [3:0] cycles_left;
  reg [3:0] total_cycles;
  reg in_instr;
  reg xdata;
  reg is_write;
  reg [4:0] strobe_left;
  reg strobe_falling;
  wire [3:0] dec_cycles;
  wire dec_xdata;
  wire dec_write;
  wire [2:0] stretch;
  wire st1;
  wire st4;
  reg [4:0] next_strobe_len;

  assign stretch = clock_control_register[`STRETCH_MSB:`STRETCH_LSB];

  state_ring u_ring
  (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .hold_in(1'b0),
    .state_out(state_out)
  );

  cycle_length_decode u_dec
  (
    .opcode_in(code_byte_in),
    .stretch_in(stretch),
    .cycles_out(dec_cycles),
    .xdata_out(dec_xdata),
    .write_out(dec_write)
  );

  assign st1 = state_out[0];
  assign st4 = state_out[3];

  always @*
  begin
    if (stretch == 3'h0)
      next_strobe_len = `STROBE_ZERO_CLOCKS;
    else
      next_strobe_len = {stretch, 2'b00};
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
      clock_control_register <= {5'h00, `STRETCH_RESET};
    else if (ce_in && clock_control_register_wr_in)
      clock_control_register <= clock_control_register_data_in;
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
      clock_control_register_out <= {5'h00, `STRETCH_RESET};
    else if (ce_in)
      clock_control_register_out <= clock_control_register;
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      opcode <= 8'h00;
      cycles_left <= 4'h0;
      total_cycles <= 4'h0;
      in_instr <= 1'b0;
      xdata <= 1'b0;
      is_write <= 1'b0;
      fetch_out <= 1'b0;
      instr_done_out <= 1'b0;
    end
    else if (ce_in)
    begin
      fetch_out <= 1'b0;
      instr_done_out <= 1'b0;
      if (st1 && !in_instr)
      begin
        // one byte fetched per machine cycle
        fetch_out <= 1'b1;
        opcode <= code_byte_in;
        // only data moves use the stretched count
        cycles_left <= dec_cycles;
        total_cycles <= dec_cycles;
        xdata <= dec_xdata;
        is_write <= dec_write;
        in_instr <= 1'b1;
      end
      else if (st1 && in_instr && !xdata &&
               (total_cycles - cycles_left) < 4'h5)
        fetch_out <= 1'b1;
      if (st4 && in_instr)
      begin
        if (cycles_left == 4'h1)
        begin
          in_instr <= 1'b0;
          instr_done_out <= 1'b1;
          xdata <= 1'b0;
        end
        cycles_left <= cycles_left - 4'h1;
      end
    end
  end

  // falling-edge flag strobe_falling is unused; release is on the rising edge
  always @(negedge clk_in)
  begin
    if (!rst_b_in)
      strobe_falling <= 1'b0;
    else if (ce_in)
      strobe_falling <= (strobe_left == 5'h01);
  end

  always @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      strobe_left <= 5'h00;
      ext_addr_out <= 16'h0000;
      ext_addr_valid_out <= 1'b0;
      rd_b_out <= 1'b1;
      wr_b_out <= 1'b1;
    end
    else if (ce_in)
    begin
      // address driven in cycle after the fetch
      // second bus access after the fetch
      if (xdata && st4 && cycles_left == total_cycles)
      begin
        ext_addr_out <= xdata_addr_in;
        ext_addr_valid_out <= 1'b1;
        strobe_left <= next_strobe_len;
        rd_b_out <= is_write;
        wr_b_out <= !is_write;
      end
      else if (strobe_left != 5'h00)
      begin
        strobe_left <= strobe_left - 5'h01;
        if (strobe_left == 5'h01)
        begin
          rd_b_out <= 1'b1;
          wr_b_out <= 1'b1;
        end
      end
      else if (instr_done_out)
        ext_addr_valid_out <= 1'b0;
    end
  end
endmodule // instr_cycle_timing
`default_nettype wire

// ---- cycle_timing_defines.vh ----
// Timing constants for the machine cycle sequencer
`ifndef CYCLE_TIMING_DEFINES_VH
`define CYCLE_TIMING_DEFINES_VH
`define STATES_PER_CYCLE 3'd4
`define STRETCH_RESET 3'h1
`define STRETCH_MSB 2
`define STRETCH_LSB 0
`define STROBE_ZERO_CLOCKS 5'h02
`define OP_XDATA_RD_DPTR 8'he0
`define OP_XDATA_RD_R0 8'he2
`define OP_XDATA_RD_R1 8'he3
`define OP_XDATA_WR_DPTR 8'hf0
`define OP_XDATA_WR_R0 8'hf2
`define OP_XDATA_WR_R1 8'hf3
`endif

// ---- state_ring.v ----
// Four-state ring within each machine cycle, with a hold input
`timescale 1ns/10ps
`default_nettype none
module state_ring
(
  input wire clk_in,
  input wire rst_b_in,
  input wire ce_in,
  input wire hold_in,
  output reg [3:0] state_out
);
  // One-hot states: first, second, third, fourth
  localparam [3:0] state_first = 4'h1;
  localparam [3:0] state_fourth = 4'h8;
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
      state_out <= state_first;
    else if (ce_in && !hold_in)
    begin
      if (state_out == state_fourth)
        state_out <= state_first;
      else
        state_out <= {state_out[2:0], 1'b0};
    end
  end
endmodule // state_ring
`default_nettype wire

// ---- cycle_length_decode.v ----
// Machine cycle count per opcode
`timescale 1ns/10ps
`default_nettype none
`include "cycle_timing_defines.vh"
module cycle_length_decode
(
  input wire [7:0] opcode_in,
  input wire [2:0] stretch_in,
  output reg [3:0] cycles_out,
  output reg xdata_out,
  output reg write_out
);
  always @*
  begin
    xdata_out = 1'b0;
    write_out = 1'b0;
    cycles_out = 4'h1;
    // four length classes plus the variable move
    if (opcode_in == `OP_XDATA_RD_DPTR || opcode_in == `OP_XDATA_RD_R0 ||
        opcode_in == `OP_XDATA_RD_R1 || opcode_in == `OP_XDATA_WR_DPTR ||
        opcode_in == `OP_XDATA_WR_R0 || opcode_in == `OP_XDATA_WR_R1)
    begin
      xdata_out = 1'b1;
      write_out = opcode_in[4];
      cycles_out = {1'b0, stretch_in} + 4'h2;
    end
    // compare and bit branches take four cycles
    else if (opcode_in[7:4] == 4'hb && opcode_in[3:0] >= 4'h4)
      cycles_out = 4'h4;
    else if (opcode_in == 8'h10 || opcode_in == 8'h20 ||
             opcode_in == 8'h30 || opcode_in == 8'hd5 ||
             opcode_in == 8'h02 || opcode_in == 8'h12)
      cycles_out = 4'h4;
    // register decrement branch takes three cycles
    else if (opcode_in[7:3] == 5'h1b)
      cycles_out = 4'h3;
    else if (opcode_in[4:0] == 5'h01 || opcode_in[4:0] == 5'h11 ||
             opcode_in == 8'h80 || opcode_in == 8'h60 ||
             opcode_in == 8'h70 || opcode_in == 8'h40 ||
             opcode_in == 8'h50)
      cycles_out = 4'h3;
    // low nibble 0, 2 or 5, and 22, 32, 73, are two-cycle; the rest single-cycle
    else if (opcode_in[3:0] == 4'h2 || opcode_in[3:0] == 4'h5 ||
             opcode_in[3:0] == 4'h0 || opcode_in == 8'h22 ||
             opcode_in == 8'h32 || opcode_in == 8'h73)
      cycles_out = 4'h2;
    else
      cycles_out = 4'h1;
  end
endmodule // cycle_length_decode
`default_nettype wire

// ---- instr_cycle_timing_checker.sv ----
// Timing assertions for the instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module instr_cycle_timing_checker
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic [7:0] clock_control_register_out,
  input wire logic [3:0] state_out,
  input wire logic fetch_out,
  input wire logic [15:0] ext_addr_out,
  input wire logic ext_addr_valid_out,
  input wire logic rd_b_out,
  input wire logic wr_b_out
);
  logic [5:0] low_cnt;
  wire [2:0] sv = clock_control_register_out[2:0];
  wire strobe_b = rd_b_out & wr_b_out;
  wire [5:0] exp_w = (sv == 3'h0) ? 6'h02 : {1'b0, sv, 2'h0};
  // Enabled clocks spent with a strobe low
  always @(posedge clk_in)
  begin
    if (!rst_b_in)
      low_cnt <= 6'h00;
    else if (ce_in)
      low_cnt <= strobe_b ? 6'h00 : low_cnt + 6'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_strobe_end;
    $rose(strobe_b);
  endsequence
  sequence s_in_reset;
    (!rst_b_in && ce_in) [*2];
  endsequence
  AST_STROBE_WIDTH: assert property (s_strobe_end |-> low_cnt == exp_w)
    else $error("strobe width wrong");
  AST_ONE_HOT: assert property ($onehot(state_out))
    else $error("state not one-hot");
  AST_RING_ORDER: assert property (state_out != $past(state_out) |->
    state_out == {$past(state_out[2:0]), $past(state_out[3])})
    else $error("state order wrong");
  AST_ONE_STROBE: assert property (rd_b_out || wr_b_out)
    else $error("both strobes low");
  AST_ADDR_VALID: assert property (!strobe_b |-> ext_addr_valid_out)
    else $error("strobe without address");
  AST_ADDR_HOLD: assert property (!strobe_b && $past(!strobe_b) |->
    $stable(ext_addr_out)) else $error("address moved");
  AST_FETCH_ONCE: assert property (fetch_out && ce_in |=> !fetch_out)
    else $error("fetch pulse too long");
  AST_RESET_REG: assert property (disable iff (1'b0) s_in_reset |=>
    sv == 3'h1 && strobe_b) else $error("reset values wrong");
endmodule // instr_cycle_timing_checker
bind instr_cycle_timing instr_cycle_timing_checker i_chk (.clk_in, .rst_b_in,
  .ce_in, .clock_control_register_out, .state_out, .fetch_out, .ext_addr_out,
  .ext_addr_valid_out, .rd_b_out, .wr_b_out);
`default_nettype wire

// ---- xdata_mem_model.sv ----
// External data memory stand-in that logs strobes
`timescale 1ns/10ps
`default_nettype none
module xdata_mem_model
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic rd_b_in,
  input wire logic wr_b_in,
  input wire logic [15:0] addr_in,
  output logic [7:0] rd_cnt_out,
  output logic [7:0] wr_cnt_out,
  output logic [15:0] addr_seen_out
);
  logic rd_q, wr_q;
  always @(posedge clk_in)
  begin
    rd_q <= rd_b_in;
    wr_q <= wr_b_in;
    if (!rst_b_in)
    begin
      rd_cnt_out <= 8'h00;
      wr_cnt_out <= 8'h00;
    end
    else if ((rd_q & !rd_b_in) | (wr_q & !wr_b_in))
    begin
      rd_cnt_out <= rd_cnt_out + {7'h00, !rd_b_in};
      wr_cnt_out <= wr_cnt_out + {7'h00, !wr_b_in};
      addr_seen_out <= addr_in;
    end
  end
endmodule // xdata_mem_model
`default_nettype wire

// ---- tb_instr_cycle_timing.sv ----
// Random instruction stream bench for the cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_instr_cycle_timing;
  logic clk_in = 0, rst_b_in = 0, ce_in = 1, clock_control_register_wr_in = 0;
  logic [7:0] clock_control_register_data_in = 0, code_byte_in = 8'h30, op, d;
  logic [15:0] xdata_addr_in = 0, addr, a_nxt = 0;
  logic [7:0] ops [17] = '{8'h30, 8'h10, 8'hb5, 8'hb4, 8'hb6, 8'hba, 8'hbf,
    8'hd5, 8'hd8, 8'hdc, 8'hdf, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
  logic [7:0] exp_rd, exp_wr;
  logic [2:0] sv = 3'h1;
  wire [7:0] clock_control_register_out, rd_cnt, wr_cnt;
  wire [3:0] state_out;
  wire fetch_out, instr_done_out, ext_addr_valid_out, rd_b_out, wr_b_out;
  wire [15:0] ext_addr_out, seen;
  int seed = 32973, fail_count = 0, samples_checked = 0;
  int n = 0, t = 0, t_last = 0, i;
  bit have = 0, nxt = 1;
  instr_cycle_timing i_dut (.clk_in, .rst_b_in, .ce_in, .clock_control_register_wr_in,
    .clock_control_register_data_in, .code_byte_in, .xdata_addr_in, .clock_control_register_out,
    .state_out, .fetch_out, .instr_done_out, .ext_addr_out, .ext_addr_valid_out,
    .rd_b_out, .wr_b_out);
  xdata_mem_model i_mem (.clk_in, .rst_b_in, .rd_b_in(rd_b_out),
    .wr_b_in(wr_b_out), .addr_in(ext_addr_out), .rd_cnt_out(rd_cnt),
    .wr_cnt_out(wr_cnt), .addr_seen_out(seen));
  always #2.5 clk_in = ~clk_in;
  function automatic [15:0] exp_len(input [7:0] o, input [2:0] s);
    if (o[7:5] == 3'h7)
      return 16'(4 * (s + 2));
    return (o[7:3] == 5'h1b) ? 16'h000c : 16'h0010;
  endfunction
  task automatic check(input string nm, input [15:0] got, input [15:0] want);
    samples_checked++;
    if (got !== want)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, want, got);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    // A write pulse must stand until an enabled edge has taken it
    if (ce_in || !rst_b_in)
      clock_control_register_wr_in <= 1'b0;
    ce_in <= !rst_b_in || ($random(seed) % 8 != 0);
    if (!rst_b_in)
    begin
      sv = 3'h1;
      have = 0;
      nxt = 1;
      exp_rd = 0;
      exp_wr = 0;
    end
    else if (ce_in)
    begin
      t++;
      if (instr_done_out)
      begin
        if (have) check("len", 16'(t - t_last), exp_len(op, sv));
        if (op[7:5] == 3'h7)
        begin
          if (op[4]) exp_wr++; else exp_rd++;
          check("acc", {wr_cnt, rd_cnt}, {exp_wr, exp_rd});
          check("addr", seen, addr);
        end
        have = 1;
        nxt = 1;
        t_last = t;
        n++;
        a_nxt = $random(seed);
        xdata_addr_in <= a_nxt;
      end
      // Only the opcode fetch starts an instruction; operand fetches pass
      if (fetch_out && nxt)
      begin
        nxt = 0;
        op = code_byte_in;
        addr = a_nxt;
        code_byte_in <= ops[$unsigned($random(seed)) % 17];
        check("ctrl", 16'(clock_control_register_out[2:0]), 16'(sv));
        if (op[7:5] != 3'h7 && $random(seed) % 3 == 0)
        begin
          d = $random(seed);
          sv = d[2:0];
          clock_control_register_data_in <= d;
          clock_control_register_wr_in <= 1'b1;
        end
      end
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 20000 && n < 100; i++) @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (i = 0; i < 20000 && n < 220; i++) @(posedge clk_in);
    results;
  end
  initial
  begin
    #250000;
    fail_count++;
    results;
  end
endmodule // tb_instr_cycle_timing
`default_nettype wire
